// file: hw/dpbsi_ctrl.sv
// Memory controller end: write buffer, link clock divider, access scheduler, read collector.
`timescale 1ns/1ps
module dpbsi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;

  // Full and empty straight from the occupancy count
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];

  // Pointers wrap on the depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == PW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == PW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage needs no reset; only counted words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule

module dpbsi_ctrl (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic latency_long,
  input wire logic wr_req_valid,
  output logic wr_req_ready,
  input wire logic [dpbsi_pkg::ADDR_W-1:0] wr_req_addr,
  input wire logic [dpbsi_pkg::BURST_W-1:0] wr_req_data,
  input wire logic [dpbsi_pkg::MASK_W-1:0] wr_req_mask_n,
  input wire logic rd_req_valid,
  output logic rd_req_ready,
  input wire logic [dpbsi_pkg::ADDR_W-1:0] rd_req_addr,
  output logic rd_resp_valid,
  output logic [dpbsi_pkg::BURST_W-1:0] rd_resp_data,
  dpbsi_if.ctrl link
);
  typedef enum logic [1:0] {CW_IDLE, CW_B1, CW_B2, CW_B3} dpbsi_cw_state_t;

  dpbsi_cw_state_t cw_reg;
  logic [1:0] phase_reg;
  logic k_reg;
  logic kn_reg;
  logic slot_wr_reg;
  logic rps_n_reg;
  logic wps_n_reg;
  logic [dpbsi_pkg::ADDR_W-1:0] addr_reg;
  logic [dpbsi_pkg::DATA_W-1:0] d_reg;
  logic [dpbsi_pkg::LANES-1:0] m_reg;
  logic [dpbsi_pkg::FIFO_W-1:0] hold_reg;
  logic [dpbsi_pkg::DATA_W-1:0] q_s1_reg;
  logic [dpbsi_pkg::DATA_W-1:0] q_s2_reg;
  logic v_s1_reg;
  logic v_s2_reg;
  logic [1:0] rb_cnt_reg;
  logic [dpbsi_pkg::BURST_W-1:0] rb_data_reg;
  logic rsp_v_reg;
  logic [dpbsi_pkg::BURST_W-1:0] rsp_d_reg;
  logic fifo_valid;
  logic [dpbsi_pkg::FIFO_W-1:0] fifo_word;

  // Setup points sit mid-way in each half period so the device samples settled pins
  wire setup_pos = (phase_reg == dpbsi_pkg::PH_FALL);
  wire setup_neg = (phase_reg == dpbsi_pkg::PH_RISE);
  wire wr_go = setup_pos && slot_wr_reg && (cw_reg == CW_IDLE) && fifo_valid;
  wire rd_go = setup_pos && !slot_wr_reg && rd_req_valid;
  wire k_next = (phase_reg == dpbsi_pkg::PH_LOW) || (phase_reg == dpbsi_pkg::PH_RISE);
  wire [dpbsi_pkg::BURST_W-1:0] hold_data = hold_reg[dpbsi_pkg::BURST_W-1:0];
  wire [dpbsi_pkg::MASK_W-1:0] hold_mask =
    hold_reg[dpbsi_pkg::FW_MASK_LSB +: dpbsi_pkg::MASK_W];
  wire take_beat = (setup_pos || setup_neg) && v_s2_reg;

  // Writes queue here; the link drains one burst every other link cycle
  dpbsi_fifo #(
    .WIDTH(dpbsi_pkg::FIFO_W),
    .DEPTH(dpbsi_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(sys_clk),
    .resetn(resetn),
    .in_valid(wr_req_valid),
    .in_ready(wr_req_ready),
    .in_data({wr_req_addr, wr_req_mask_n, wr_req_data}),
    .out_valid(fifo_valid),
    .out_ready(wr_go),
    .out_data(fifo_word)
  );

  // Link clock pair from a divide-by-four of sys_clk
  // Reset parks the phase just ahead of a rise, so the first high period is full length
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      phase_reg <= dpbsi_pkg::PH_LOW;
      k_reg <= 1'b0;
      kn_reg <= 1'b1;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      k_reg <= k_next;
      kn_reg <= !k_next;
    end
  end

  // Access slots alternate, since the shared address bus carries one address per cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      slot_wr_reg <= 1'b0;
      rps_n_reg <= 1'b1;
      wps_n_reg <= 1'b1;
      addr_reg <= '0;
    end else if (setup_pos) begin
      slot_wr_reg <= !slot_wr_reg;
      rps_n_reg <= !rd_go;
      wps_n_reg <= !wr_go;
      if (wr_go) begin
        addr_reg <= fifo_word[dpbsi_pkg::FW_ADDR_LSB +: dpbsi_pkg::ADDR_W];
      end else if (rd_go) begin
        addr_reg <= rd_req_addr;
      end
    end
  end

  // Write beats: 0 and 2 ahead of true rises, 1 and 3 ahead of complement rises
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cw_reg <= CW_IDLE;
      d_reg <= '0;
      m_reg <= '1;
      hold_reg <= '0;
    end else if (wr_go) begin
      cw_reg <= CW_B1;
      hold_reg <= fifo_word;
      d_reg <= dpbsi_pkg::beat(fifo_word[dpbsi_pkg::BURST_W-1:0], 0);
      m_reg <= dpbsi_pkg::lanes(fifo_word[dpbsi_pkg::FW_MASK_LSB +: dpbsi_pkg::MASK_W], 0);
    end else if (setup_neg && cw_reg == CW_B1) begin
      cw_reg <= CW_B2;
      d_reg <= dpbsi_pkg::beat(hold_data, 1);
      m_reg <= dpbsi_pkg::lanes(hold_mask, 1);
    end else if (setup_pos && cw_reg == CW_B2) begin
      cw_reg <= CW_B3;
      d_reg <= dpbsi_pkg::beat(hold_data, 2);
      m_reg <= dpbsi_pkg::lanes(hold_mask, 2);
    end else if (setup_neg && cw_reg == CW_B3) begin
      cw_reg <= CW_IDLE;
      d_reg <= dpbsi_pkg::beat(hold_data, 3);
      m_reg <= dpbsi_pkg::lanes(hold_mask, 3);
    end
  end

  // Read pins come from the device's launch, so both pass two flops first
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q_s1_reg <= '0;
      q_s2_reg <= '0;
      v_s1_reg <= 1'b0;
      v_s2_reg <= 1'b0;
    end else begin
      q_s1_reg <= link.q;
      q_s2_reg <= q_s1_reg;
      v_s1_reg <= link.output_valid_flag;
      v_s2_reg <= v_s1_reg;
    end
  end

  // Collect four valid beats into one word; limitation: a lost beat shifts later bursts
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rb_cnt_reg <= '0;
      rb_data_reg <= '0;
      rsp_v_reg <= 1'b0;
      rsp_d_reg <= '0;
    end else begin
      rsp_v_reg <= take_beat && (rb_cnt_reg == dpbsi_pkg::LAST_BEAT);
      if (take_beat) begin
        rb_cnt_reg <= rb_cnt_reg + 2'h1;
        rb_data_reg[int'(rb_cnt_reg)*dpbsi_pkg::DATA_W +: dpbsi_pkg::DATA_W] <= q_s2_reg;
        if (rb_cnt_reg == dpbsi_pkg::LAST_BEAT) begin
          rsp_d_reg <= {q_s2_reg, rb_data_reg[dpbsi_pkg::BURST_W-dpbsi_pkg::DATA_W-1:0]};
        end
      end
    end
  end

  // Pin and user outputs
  assign rd_req_ready = setup_pos && !slot_wr_reg;
  assign rd_resp_valid = rsp_v_reg;
  assign rd_resp_data = rsp_d_reg;
  assign link.k = k_reg;
  assign link.k_n = kn_reg;
  assign link.loop_bypass_n = latency_long;
  assign link.read_port_select_n = rps_n_reg;
  assign link.write_port_select_n = wps_n_reg;
  assign link.addr = addr_reg;
  assign link.d = d_reg;
  assign link.byte_lane_write_select_n = m_reg;
endmodule

// file: hw/dpbsi_sram_dev.sv
// Burst SRAM end: double data rate write and read ports on the link clocks.
`timescale 1ns/1ps
module dpbsi_sram_dev (
  dpbsi_if.device link
);
  typedef enum logic [1:0] {WR_IDLE, WR_FIRST, WR_SECOND} dpbsi_wr_state_t;

  // No reset pin exists, so the control flops start from declared values
  dpbsi_wr_state_t wr_state_reg = WR_IDLE;
  dpbsi_wr_state_t wr_state_next;
  logic [dpbsi_pkg::ADDR_W-1:0] wr_addr_reg = '0;
  logic [dpbsi_pkg::DATA_W-1:0] pos_d_reg = '0;
  logic [dpbsi_pkg::LANES-1:0] pos_m_reg = '1;
  logic [dpbsi_pkg::DATA_W-1:0] neg_d_reg = '0;
  logic [dpbsi_pkg::LANES-1:0] neg_m_reg = '1;
  logic [dpbsi_pkg::BURST_W-1:0] mem_reg [0:dpbsi_pkg::ARR_DEPTH-1];
  logic [dpbsi_pkg::BURST_W-1:0] st_d_reg [0:3];
  logic [3:0] st_v_reg = '0;
  logic lb_s1_reg = 1'b1;
  logic lb_s2_reg = 1'b1;
  logic [dpbsi_pkg::DATA_W-1:0] pos_q_reg = '0;
  logic pos_v_reg = 1'b0;
  logic [dpbsi_pkg::DATA_W-1:0] pend_q_reg = '0;
  logic pend_v_reg = 1'b0;
  logic [dpbsi_pkg::DATA_W-1:0] neg_q_reg = '0;
  logic neg_v_reg = 1'b0;

  // Decode of port selects; addresses are looked at only when selected
  wire wr_start = !link.write_port_select_n && (wr_state_reg != WR_FIRST);
  wire rd_start = !link.read_port_select_n;
  wire wr_busy = (wr_state_reg != WR_IDLE);
  wire wr_half = (wr_state_reg == WR_SECOND);
  wire [dpbsi_pkg::ARR_BITS-1:0] wr_idx = wr_addr_reg[dpbsi_pkg::ARR_BITS-1:0];
  wire [dpbsi_pkg::ARR_BITS-1:0] rd_idx = link.addr[dpbsi_pkg::ARR_BITS-1:0];
  wire [dpbsi_pkg::BURST_W-1:0] wr_old = mem_reg[wr_idx];
  wire [dpbsi_pkg::BURST_W-1:0] rd_word = mem_reg[rd_idx];
  wire [1:0] beat_a = {wr_half, 1'b0};
  wire [1:0] beat_b = {wr_half, 1'b1};
  logic [dpbsi_pkg::BURST_W-1:0] wr_new;

  // Write sequencer: first cycle holds beats 0,1; second cycle beats 2,3
  always_comb begin
    case (wr_state_reg)
      WR_FIRST: wr_state_next = WR_SECOND;
      WR_IDLE,
      WR_SECOND: wr_state_next = wr_start ? WR_FIRST : WR_IDLE;
      default: wr_state_next = WR_IDLE;
    endcase
  end

  // Merge the two beats of this half into the stored burst word
  always_comb begin
    wr_new = wr_old;
    wr_new[int'(beat_a)*dpbsi_pkg::DATA_W +: dpbsi_pkg::DATA_W] =
      dpbsi_pkg::merge(dpbsi_pkg::beat(wr_old, int'(beat_a)), pos_d_reg, pos_m_reg);
    wr_new[int'(beat_b)*dpbsi_pkg::DATA_W +: dpbsi_pkg::DATA_W] =
      dpbsi_pkg::merge(dpbsi_pkg::beat(wr_old, int'(beat_b)), neg_d_reg, neg_m_reg);
  end

  // True-clock capture of write address and the even beats with their selects
  always_ff @(posedge link.k) begin
    wr_state_reg <= wr_state_next;
    if (wr_start) begin
      wr_addr_reg <= link.addr;
    end
    if (wr_start || wr_state_reg == WR_FIRST) begin
      pos_d_reg <= link.d;
      pos_m_reg <= link.byte_lane_write_select_n;
    end
  end

  // Array update; a read on the same edge sees the contents before it
  always_ff @(posedge link.k) begin
    if (wr_busy) begin
      mem_reg[wr_idx] <= wr_new;
    end
  end

  // Complement-clock capture of the odd beats; ignored outside a write
  always_ff @(posedge link.k_n) begin
    if (wr_busy) begin
      neg_d_reg <= link.d;
      neg_m_reg <= link.byte_lane_write_select_n;
    end
  end

  // Read pipeline: the burst word ages one stage per true-clock cycle
  always_ff @(posedge link.k) begin
    st_v_reg <= {st_v_reg[2:0], rd_start};
    if (rd_start) begin
      st_d_reg[0] <= rd_word;
    end
    for (int i = 1; i < 4; i++) begin
      st_d_reg[i] <= st_d_reg[i-1];
    end
  end

  // Static bypass pin comes from outside the link domain, so it is synchronised
  always_ff @(posedge link.k) begin
    lb_s1_reg <= link.loop_bypass_n;
    lb_s2_reg <= lb_s1_reg;
  end

  // Beat schedule: long mode starts half a cycle later and one cycle more
  wire long_mode = lb_s2_reg;
  wire pos_v_sel = long_mode ? (st_v_reg[2] || st_v_reg[3]) : (st_v_reg[0] || st_v_reg[1]);
  wire neg_v_sel = long_mode ? (st_v_reg[1] || st_v_reg[2]) : (st_v_reg[0] || st_v_reg[1]);
  wire [dpbsi_pkg::DATA_W-1:0] pos_long =
    st_v_reg[2] ? dpbsi_pkg::beat(st_d_reg[2], 1) : dpbsi_pkg::beat(st_d_reg[3], 3);
  wire [dpbsi_pkg::DATA_W-1:0] neg_long =
    st_v_reg[1] ? dpbsi_pkg::beat(st_d_reg[1], 0) : dpbsi_pkg::beat(st_d_reg[2], 2);
  wire [dpbsi_pkg::DATA_W-1:0] pos_short =
    st_v_reg[0] ? dpbsi_pkg::beat(st_d_reg[0], 0) : dpbsi_pkg::beat(st_d_reg[1], 2);
  wire [dpbsi_pkg::DATA_W-1:0] neg_short =
    st_v_reg[0] ? dpbsi_pkg::beat(st_d_reg[0], 1) : dpbsi_pkg::beat(st_d_reg[1], 3);

  // True-clock launch of beats 0,2 in short mode or 1,3 in long mode, the other beat of each pair prepared for the complement
  always_ff @(posedge link.k) begin
    pos_q_reg <= long_mode ? pos_long : pos_short;
    pos_v_reg <= pos_v_sel;
    pend_q_reg <= long_mode ? neg_long : neg_short;
    pend_v_reg <= neg_v_sel;
  end

  // Complement-clock launch of the prepared beat
  always_ff @(posedge link.k_n) begin
    neg_q_reg <= pend_q_reg;
    neg_v_reg <= pend_v_reg;
  end

  // Output mux: true-clock half shows the true beat, the other half the complement beat
  assign link.q = link.k ? pos_q_reg : neg_q_reg;
  assign link.output_valid_flag = link.k ? pos_v_reg : neg_v_reg;
  // Drivers float once no beat is scheduled, so a deselect lets the burst finish first
  assign link.q_oe = link.output_valid_flag;
  // Echo strobes are the input clocks passed straight back, hence free running
  assign link.echo_strobe = link.k;
  assign link.echo_strobe_n = link.k_n;
endmodule

// file: pkg/dpbsi_if.sv
// Pin bundle between the memory controller and the burst SRAM.
`timescale 1ns/1ps
interface dpbsi_if;
  logic k;
  logic k_n;
  logic loop_bypass_n;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [dpbsi_pkg::ADDR_W-1:0] addr;
  logic [dpbsi_pkg::DATA_W-1:0] d;
  logic [dpbsi_pkg::LANES-1:0] byte_lane_write_select_n;
  logic [dpbsi_pkg::DATA_W-1:0] q;
  logic q_oe;
  logic output_valid_flag;
  logic echo_strobe;
  logic echo_strobe_n;

  modport device (
    input k,
    input k_n,
    input loop_bypass_n,
    input read_port_select_n,
    input write_port_select_n,
    input addr,
    input d,
    input byte_lane_write_select_n,
    output q,
    output q_oe,
    output output_valid_flag,
    output echo_strobe,
    output echo_strobe_n
  );

  modport ctrl (
    output k,
    output k_n,
    output loop_bypass_n,
    output read_port_select_n,
    output write_port_select_n,
    output addr,
    output d,
    output byte_lane_write_select_n,
    input q,
    input q_oe,
    input output_valid_flag,
    input echo_strobe,
    input echo_strobe_n
  );
endinterface

// file: pkg/dpbsi_pkg.sv
// Shared constants, field layouts and helper functions of the burst SRAM link.
package dpbsi_pkg;
  // Link widths for the 18-bit configuration
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int ADDR_W = 21;
  localparam int BEATS = 4;
  localparam int BURST_W = DATA_W * BEATS;
  localparam int MASK_W = LANES * BEATS;
  // Array model holds a window of burst locations, indexed by low address bits
  localparam int ARR_BITS = 8;
  localparam int ARR_DEPTH = 1 << ARR_BITS;
  // Write buffer word: {address, lane selects, burst data}
  localparam int FIFO_DEPTH = 8;
  localparam int FW_MASK_LSB = BURST_W;
  localparam int FW_ADDR_LSB = BURST_W + MASK_W;
  localparam int FIFO_W = ADDR_W + MASK_W + BURST_W;
  // Quarter phases of the link clock made from sys_clk; the clock is high in RISE and HIGH
  localparam logic [1:0] PH_RISE = 2'h0;
  localparam logic [1:0] PH_HIGH = 2'h1;
  localparam logic [1:0] PH_FALL = 2'h2;
  localparam logic [1:0] PH_LOW = 2'h3;
  localparam logic [1:0] LAST_BEAT = 2'h3;

  // Replace only the lanes whose active-low select is asserted
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [LANES-1:0] sel_n);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < LANES; i++) begin
      if (!sel_n[i]) begin
        r[i*LANE_W +: LANE_W] = new_v[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  // One beat out of a four-beat burst word, beat 0 in the low bits
  function automatic logic [DATA_W-1:0] beat(input logic [BURST_W-1:0] w, input int idx);
    return w[idx*DATA_W +: DATA_W];
  endfunction

  // Lane selects belonging to one beat
  function automatic logic [LANES-1:0] lanes(input logic [MASK_W-1:0] m, input int idx);
    return m[idx*LANES +: LANES];
  endfunction
endpackage

// file: tb/dpbsi_link_assertions.sv
// Link checks between the controller end and the burst SRAM end.
`timescale 1ns/1ps
module dpbsi_link_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic k,
  input wire logic k_n,
  input wire logic loop_bypass_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic q_oe,
  input wire logic output_valid_flag,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n
);
  logic [3:0] mode_age_reg;
  logic [3:0] rd_idle_reg;
  logic [3:0] mode_age_next;
  logic settled;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Latency mode needs two link edges to cross, so bursts are timed only once it settles
  assign mode_age_next = (mode_age_reg == 4'hf) ? mode_age_reg : mode_age_reg + 4'h1;
  assign settled = (mode_age_reg == 4'hf);
  always_ff @(posedge sys_clk) begin
    mode_age_reg <= (!resetn || $changed(loop_bypass_n)) ? 4'h0 : mode_age_next;
  end
  // Cycles since the read select was last low; a long burst is over 15 cycles after it rises
  always_ff @(posedge sys_clk) begin
    if (!resetn || !read_port_select_n) begin
      rd_idle_reg <= 4'h0;
    end else if (rd_idle_reg != 4'hf) begin
      rd_idle_reg <= rd_idle_reg + 4'h1;
    end
  end
  a_echo_tracks_k: assert property (echo_strobe == k && echo_strobe_n == k_n)
    else $error("echo strobes differ from link clocks");
  a_clock_pair: assert property (k_n == !k)
    else $error("complement clock not inverse of true clock");
  a_k_duty: assert property ($rose(k) |-> ##1 k ##1 !k [*2] ##1 k)
    else $error("link clock period wrong");
  a_oe_floats: assert property (q_oe |-> rd_idle_reg != 4'hf)
    else $error("read drivers left on after the burst");
  a_valid_on_edge: assert property ($changed(output_valid_flag) |-> $changed(k))
    else $error("valid flag moved off a link edge");
  a_short_burst: assert property (settled && !loop_bypass_n && $rose(k) &&
      !read_port_select_n |-> ##4 output_valid_flag [*8])
    else $error("short latency burst misplaced");
  a_long_burst: assert property (settled && loop_bypass_n && $rose(k) &&
      !read_port_select_n |-> ##10 output_valid_flag [*8])
    else $error("long latency burst misplaced");
  a_wsel_one_cycle: assert property ($fell(write_port_select_n) |->
      (!write_port_select_n) [*4] ##1 write_port_select_n)
    else $error("write select not one link cycle");
  a_ports_exclusive: assert property (read_port_select_n || write_port_select_n)
    else $error("read and write selected together");
endmodule

// file: tb/dual_port_burst_sram_interface_tb.sv
// Self-checking bench: controller and burst SRAM joined over the link.
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module dual_port_burst_sram_interface_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic latency_long = 1'b1;
  logic wr_req_valid = 1'b0;
  logic wr_req_ready;
  logic [dpbsi_pkg::ADDR_W-1:0] wr_req_addr = '0;
  logic [dpbsi_pkg::BURST_W-1:0] wr_req_data = '0;
  logic [dpbsi_pkg::MASK_W-1:0] wr_req_mask_n = '0;
  logic rd_req_valid = 1'b0;
  logic rd_req_ready;
  logic [dpbsi_pkg::ADDR_W-1:0] rd_req_addr = '0;
  logic rd_resp_valid;
  logic [dpbsi_pkg::BURST_W-1:0] rd_resp_data;
  int err_total = 0;
  int num_checks = 0;
  dpbsi_if link_if();
  // 20 MHz system clock; the controller divides it for the link
  always #25 sys_clk = ~sys_clk;
  dpbsi_ctrl u_dpbsi_ctrl (.sys_clk(sys_clk), .resetn(resetn), .latency_long(latency_long),
    .wr_req_valid(wr_req_valid), .wr_req_ready(wr_req_ready), .wr_req_addr(wr_req_addr),
    .wr_req_data(wr_req_data), .wr_req_mask_n(wr_req_mask_n), .rd_req_valid(rd_req_valid),
    .rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr), .rd_resp_valid(rd_resp_valid),
    .rd_resp_data(rd_resp_data), .link(link_if));
  dpbsi_sram_dev u_dpbsi_sram_dev (.link(link_if));
  dpbsi_link_assertions chk_link (.sys_clk(sys_clk), .resetn(resetn), .k(link_if.k),
    .k_n(link_if.k_n), .loop_bypass_n(link_if.loop_bypass_n),
    .read_port_select_n(link_if.read_port_select_n),
    .write_port_select_n(link_if.write_port_select_n), .q_oe(link_if.q_oe),
    .output_valid_flag(link_if.output_valid_flag), .echo_strobe(link_if.echo_strobe),
    .echo_strobe_n(link_if.echo_strobe_n));

  function automatic logic [71:0] pat(input int i);
    return {4{i[17:0]}} ^ 72'hAB_1234_5678_9ABC_DEF0;
  endfunction

  // Offer one write at a falling edge; returns with valid still high
  task automatic wr(input logic [20:0] a, input logic [71:0] dat, input logic [7:0] m);
    int n;
    n = 0;
    wr_req_valid = 1'b1;
    wr_req_addr = a;
    wr_req_data = dat;
    wr_req_mask_n = m;
    while (wr_req_ready !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 200) err_total++;
    @(negedge sys_clk);
  endtask

  // Writes are done once the write select stayed idle for 16 cycles
  task automatic drain();
    int idle;
    int n;
    idle = 0;
    n = 0;
    wr_req_valid = 1'b0;
    while (idle < 16 && n < 400) begin
      @(negedge sys_clk);
      idle = (link_if.write_port_select_n === 1'b1) ? idle + 1 : 0;
      n++;
    end
    if (idle < 16) err_total++;
  endtask

  task automatic rd(input logic [20:0] a, output logic [71:0] dat);
    int n;
    n = 0;
    rd_req_valid = 1'b1;
    rd_req_addr = a;
    while (rd_req_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    rd_req_valid = 1'b0;
    while (rd_resp_valid !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    dat = rd_resp_data;
    if (rd_resp_valid !== 1'b1) err_total++;
  endtask

  // Full burst round trip in long and then short latency mode
  task automatic t_modes();
    logic [71:0] got;
    for (int mode = 1; mode >= 0; mode--) begin
      latency_long = mode[0];
      repeat (20) @(negedge sys_clk);
      wr(21'h1F_FF00 + 21'(mode), pat(mode + 7), 8'h00);
      drain();
      rd(21'h1F_FF00 + 21'(mode), got);
      `CHK(got, pat(mode + 7))
    end
    $display("t_modes done");
  endtask

  // Per-beat lane selects merge a second burst over the first
  task automatic t_lanes();
    logic [71:0] got;
    logic [71:0] exp;
    logic [7:0] m;
    m = 8'h36;
    wr(21'h00_0042, pat(3), 8'h00);
    wr(21'h00_0042, pat(9), m);
    drain();
    for (int j = 0; j < 8; j++) begin
      exp[j*9 +: 9] = 9'(m[j] ? pat(3) >> (j * 9) : pat(9) >> (j * 9));
    end
    rd(21'h00_0042, got);
    `CHK(got, exp)
    $display("t_lanes done");
  endtask

  // Fill the write buffer until it refuses, then read every burst back
  task automatic t_fill();
    logic [71:0] got;
    int n;
    n = 0;
    wr_req_valid = 1'b1;
    wr_req_mask_n = 8'h00;
    while (wr_req_ready === 1'b1 && n < 16) begin
      wr_req_addr = 21'h00_0080 + 21'(n);
      wr_req_data = pat(n);
      @(negedge sys_clk);
      n++;
    end
    `CHK((n >= 8) && (n < 16), 1'b1)
    drain();
    for (int i = 0; i < n; i++) begin
      rd(21'h00_0080 + 21'(i), got);
      `CHK(got, pat(i))
    end
    $display("t_fill done");
  endtask

  // Reads in neighbouring slots, bursts back to back on the link
  task automatic t_rd_pair();
    logic [71:0] got [2];
    int n;
    int c;
    n = 0;
    c = 0;
    rd_req_valid = 1'b1;
    for (int i = 0; i < 2; i++) begin
      rd_req_addr = 21'h00_0080 + 21'(i);
      while (rd_req_ready !== 1'b1 && n < 100) begin
        @(negedge sys_clk);
        n++;
      end
      @(negedge sys_clk);
    end
    rd_req_valid = 1'b0;
    while (c < 2 && n < 200) begin
      if (rd_resp_valid === 1'b1) begin
        got[c] = rd_resp_data;
        c++;
      end
      @(negedge sys_clk);
      n++;
    end
    if (c < 2) err_total++;
    `CHK(got[0], pat(0))
    `CHK(got[1], pat(1))
    $display("t_rd_pair done");
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    t_modes();
    t_lanes();
    t_fill();
    t_rd_pair();
    summarize();
  end
endmodule
